// >>> verilog/remote_config_request_frame.sv
// parser for the remote configuration request frame on the serial api
// Behaviour
// R1 - frame begins with start delimiter byte at offset zero
// R2 - 16-bit length counts bytes between length field and checksum
// R3 - type byte at offset three must be the remote request code
// R4 - correlation id at offset four; zero means no response
// R5 - response carries the request's correlation id back to host
// R6 - host puts 64-bit address at offset five, all-ones if unused
// R7 - host puts 16-bit address at offset thirteen, or unknown value
// R8 - option bit 0 suppresses acknowledgement
// R9 - option bit 1 applies now; otherwise change stays pending
// R10 - option bit 4 asks secure delivery, needs an open session
// R11 - host keeps reserved and unused option bits at zero
// R12 - offset sixteen holds two ascii parameter name characters
// R13 - bytes from offset eighteen to checksum are the new value
// R14 - no value bytes means query; return current value
// R15 - checksum is 0xff minus low byte of sum from offset three
// R16 - host sends these only as unicast, not broadcast
// R17 - discard frames with bad checksum or length
`timescale 1ns/1ps
module remote_config_request_frame
    import rcf_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic [7:0]              rxData,
    input  wire logic                    rxValid,
    input  wire logic                    secureSession,
    input  wire logic                    applyPendingChangesCommand,
    output logic                         reqValid,
    output logic [7:0]                   reqId,
    output logic                         rspWanted,
    output logic [7:0]                   rspType,
    output logic [63:0]                  reqAddr64,
    output logic [15:0]                  reqAddr16,
    output logic                         reqNoAck,
    output logic                         reqApply,
    output logic                         reqSecure,
    output logic [15:0]                  reqCmd,
    output logic [4:0]                   reqParamLen,
    output logic [PARAM_MAX*8-1:0]       reqParam,
    output logic                         reqQuery,
    output logic                         reqWrite,
    output logic                         applyNow,
    output logic                         pendingChange,
    output logic                         frameDropped
);

    // ==========================================================
    // state
    rcf_state_t                 state_reg;
    logic [15:0]                len_reg;
    logic [15:0]                pos_reg;
    logic [7:0]                 id_reg;
    logic [63:0]                addr64_reg;
    logic [15:0]                addr16_reg;
    logic [7:0]                 opt_reg;
    logic [15:0]                cmd_reg;
    logic [7:0]                 param_reg [PARAM_MAX];
    logic                       typeOk_reg;
    logic                       secureOk;
    logic                       frameGood;
    logic [15:0]                paramIdx;
    logic                       csumByte;
    logic                       acceptNow;
    logic                       dropNow;
    rcf_csum_if                 cs ();

    rcf_csum_acc u_csum
    (
        .mclk (mclk),
        .nrst (nrst),
        .cs   (cs)
    );

    // position of the byte now arriving, counted from offset eighteen
    assign paramIdx = pos_reg - OFF_PARAM;

    // cleared while hunting so a cut frame leaves no residue
    // R15 checksum accumulation
    assign cs.clear = (state_reg == RCF_IDLE);
    assign cs.add   = rxValid && (state_reg == RCF_BODY);
    assign cs.data  = rxData;

    // the checksum byte completes the running sum to 0xff
    // length outside 15..31 cannot fit the value store
    // R15 checksum check
    // R17 length check
    // R10 secure option gate
    assign secureOk  = !opt_reg[OPT_SECURE_BIT] || secureSession;
    assign frameGood = (8'(cs.sum + rxData) == CSUM_TARGET)
                       && typeOk_reg
                       && (len_reg >= LEN_QUERY)
                       && (len_reg <= LEN_QUERY + 16'(PARAM_MAX))
                       && secureOk;

    // verdict decoded once so accept and drop can never both fire
    assign csumByte  = rxValid && (state_reg == RCF_CSUM);
    assign acceptNow = csumByte && frameGood;
    assign dropNow   = csumByte && !frameGood;

    // ==========================================================
    // byte sequencer
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= RCF_IDLE;
            len_reg   <= 16'h0000;
            pos_reg   <= 16'h0000;
        end
        else if (rxValid)
        begin
            case (state_reg)
                // bytes before the start byte are ignored
                // R1 hunt for start
                RCF_IDLE:
                begin
                    if (rxData == START_DELIM)
                        state_reg <= RCF_LEN_HI;
                end
                // R2 length big-endian
                RCF_LEN_HI:
                begin
                    len_reg[15:8] <= rxData;
                    state_reg     <= RCF_LEN_LO;
                end
                RCF_LEN_LO:
                begin
                    len_reg[7:0] <= rxData;
                    pos_reg      <= OFF_TYPE;
                    // R17 a zero length frame cannot be valid
                    if ({len_reg[15:8], rxData} == 16'h0000)
                        state_reg <= RCF_CSUM;
                    else
                        state_reg <= RCF_BODY;
                end
                RCF_BODY:
                begin
                    // a start byte inside the body is data; no resync mid-frame
                    pos_reg <= pos_reg + 16'h0001;
                    // R2 body ends after length bytes
                    if (pos_reg == len_reg + OFF_TYPE - 16'h0001)
                        state_reg <= RCF_CSUM;
                end
                // verdict is taken on this same edge, then hunt again
                RCF_CSUM:
                    state_reg <= RCF_IDLE;
                default:
                    state_reg <= RCF_IDLE;
            endcase
        end
    end

    // ==========================================================
    // field capture, big-endian as on the wire
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            typeOk_reg <= 1'b0;
            id_reg     <= 8'h00;
            addr64_reg <= 64'h0000000000000000;
            addr16_reg <= 16'h0000;
            opt_reg    <= 8'h00;
            cmd_reg    <= 16'h0000;
        end
        else if (rxValid && state_reg == RCF_BODY)
        begin
            // type kept as a flag, judged at the checksum byte
            // R3 frame type check
            if (pos_reg == OFF_TYPE)
                typeOk_reg <= (rxData == REQ_TYPE);
            // R4 correlation id
            if (pos_reg == OFF_ID)
                id_reg <= rxData;
            // R6 64-bit destination
            if (pos_reg >= OFF_ADDR64 && pos_reg < OFF_ADDR16)
                addr64_reg <= {addr64_reg[55:0], rxData};
            // R7 16-bit destination
            if (pos_reg >= OFF_ADDR16 && pos_reg < OFF_OPT)
                addr16_reg <= {addr16_reg[7:0], rxData};
            // R11 reserved bits masked off, host keeps them zero
            if (pos_reg == OFF_OPT)
                opt_reg <= rxData & ~OPT_RESV_MASK;
            // R12 two character parameter name
            if (pos_reg >= OFF_CMD && pos_reg < OFF_PARAM)
                cmd_reg <= {cmd_reg[7:0], rxData};
        end
    end

    // ==========================================================
    // parameter value storage, one flip-flop byte per entry
    genvar gi;
    generate
        for (gi = 0; gi < PARAM_MAX; gi++)
        begin : g_param
            // R13 value bytes from offset eighteen
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                    param_reg[gi] <= 8'h00;
                else if (rxValid && state_reg == RCF_BODY && pos_reg >= OFF_PARAM
                         && paramIdx == 16'(gi))
                    param_reg[gi] <= rxData;
            end
            // bytes past the value length keep stale contents
            // first value byte lands in the top byte of the output
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                    reqParam[(PARAM_MAX-1-gi)*8 +: 8] <= 8'h00;
                else if (rxValid && state_reg == RCF_CSUM && frameGood)
                    reqParam[(PARAM_MAX-1-gi)*8 +: 8] <= param_reg[gi];
            end
        end
    endgenerate

    // ==========================================================
    // request presentation; outputs held until the next good frame
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            reqId       <= 8'h00;
            rspWanted   <= 1'b0;
            rspType     <= 8'h00;
            reqAddr64   <= 64'h0000000000000000;
            reqAddr16   <= 16'h0000;
            reqNoAck    <= 1'b0;
            reqApply    <= 1'b0;
            reqSecure   <= 1'b0;
            reqCmd      <= 16'h0000;
            reqParamLen <= 5'h00;
            reqQuery    <= 1'b0;
            reqWrite    <= 1'b0;
        end
        else if (rxValid && state_reg == RCF_CSUM && frameGood)
        begin
            // R5 response keeps the request id
            reqId       <= id_reg;
            rspType     <= RSP_TYPE;
            // R4 id zero means silent
            rspWanted   <= (id_reg != 8'h00);
            reqAddr64   <= addr64_reg;
            reqAddr16   <= addr16_reg;
            // R8 acknowledgement suppression
            reqNoAck    <= opt_reg[OPT_NOACK_BIT];
            reqApply    <= opt_reg[OPT_APPLY_BIT];
            reqSecure   <= opt_reg[OPT_SECURE_BIT];
            reqCmd      <= cmd_reg;
            reqParamLen <= 5'(len_reg - LEN_QUERY);
            // R14 no value bytes is a query
            reqQuery    <= (len_reg == LEN_QUERY);
            // R13 value present is a write
            reqWrite    <= (len_reg != LEN_QUERY);
        end
    end

    // ==========================================================
    // one-cycle strobes
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            reqValid     <= 1'b0;
            frameDropped <= 1'b0;
        end
        else
        begin
            // R17 bad frames are dropped without acting
            reqValid     <= acceptNow;
            frameDropped <= dropNow;
        end
    end

    // ==========================================================
    // pending change tracking; set wins over clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pendingChange <= 1'b0;
            applyNow      <= 1'b0;
        end
        else
        begin
            // a query never sets pending state; one with the apply bit clears it
            // R9 apply immediately or hold pending
            if (rxValid && state_reg == RCF_CSUM && frameGood
                && len_reg != LEN_QUERY && !opt_reg[OPT_APPLY_BIT])
                pendingChange <= 1'b1;
            else if (applyPendingChangesCommand
                     || (rxValid && state_reg == RCF_CSUM && frameGood
                         && opt_reg[OPT_APPLY_BIT]))
                pendingChange <= 1'b0;
            applyNow <= applyPendingChangesCommand
                        || (rxValid && state_reg == RCF_CSUM && frameGood
                            && opt_reg[OPT_APPLY_BIT]);
        end
    end

endmodule

// >>> verilog/rcf_pkg.sv
// constants and types for the remote configuration request frame parser
package rcf_pkg;

    // ==========================================================
    // frame layout
    localparam logic [7:0]  START_DELIM     = 8'h7e;
    localparam logic [7:0]  REQ_TYPE        = 8'h17;
    localparam logic [7:0]  RSP_TYPE        = 8'h97;
    localparam logic [7:0]  CSUM_TARGET     = 8'hff;
    localparam logic [15:0] OFF_TYPE        = 16'h0003;
    localparam logic [15:0] OFF_ID          = 16'h0004;
    localparam logic [15:0] OFF_ADDR64      = 16'h0005;
    localparam logic [15:0] OFF_ADDR16      = 16'h000d;
    localparam logic [15:0] OFF_OPT         = 16'h000f;
    localparam logic [15:0] OFF_CMD         = 16'h0010;
    localparam logic [15:0] OFF_PARAM       = 16'h0012;
    // length counts type..last param byte, so a query is 15
    localparam logic [15:0] LEN_QUERY       = 16'h000f;
    localparam int          PARAM_MAX       = 16;
    localparam logic [4:0]  PARAM_MAX_LEN   = 5'h10;

    // ==========================================================
    // option byte fields
    localparam int          OPT_NOACK_BIT   = 0;
    localparam int          OPT_APPLY_BIT   = 1;
    localparam int          OPT_SECURE_BIT  = 4;
    localparam logic [7:0]  OPT_RESV_MASK   = 8'hec;

    // ==========================================================
    // parser states
    typedef enum logic [2:0] {
        RCF_IDLE,
        RCF_LEN_HI,
        RCF_LEN_LO,
        RCF_BODY,
        RCF_CSUM
    } rcf_state_t;

endpackage

// >>> verilog/rcf_csum_if.sv
// interface carrying running checksum controls between parser and accumulator
`timescale 1ns/1ps
interface rcf_csum_if;
    logic       clear;
    logic       add;
    logic [7:0] data;
    logic [7:0] sum;
    modport ctrl (output clear, output add, output data, input sum);
    modport acc  (input clear, input add, input data, output sum);
endinterface

// >>> verilog/rcf_csum_acc.sv
// running eight bit checksum accumulator
`timescale 1ns/1ps
module rcf_csum_acc
    import rcf_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  nrst,
    rcf_csum_if.acc    cs
);

    logic [7:0] sum_reg;

    // sum wraps at eight bits by design
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            sum_reg <= 8'h00;
        else if (cs.clear)
            sum_reg <= 8'h00;
        else if (cs.add)
            sum_reg <= sum_reg + cs.data;
    end

    assign cs.sum = sum_reg;

endmodule

// >>> test/rcf_props.sv
// concurrent checks on the request frame parser ports
`timescale 1ns/1ps
module rcf_props
    import rcf_pkg::*;
(
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       secureSession,
    input wire logic       applyPendingChangesCommand,
    input wire logic       reqValid,
    input wire logic [7:0] reqId,
    input wire logic       rspWanted,
    input wire logic [7:0] rspType,
    input wire logic       reqApply,
    input wire logic       reqSecure,
    input wire logic       reqQuery,
    input wire logic       reqWrite,
    input wire logic [4:0] reqParamLen,
    input wire logic       applyNow,
    input wire logic       pendingChange,
    input wire logic       frameDropped
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // sequences
    // shortest frame is zero length: start, two length bytes, checksum
    sequence quietGap;
        (!reqValid && !frameDropped) [*3];
    endsequence
    // ==========================================================
    // properties
    a_verdict_spacing: assert property ((reqValid || frameDropped) |=> quietGap)
        else $error("verdict pulses too close together");
    a_verdict_excl: assert property (!(reqValid && frameDropped))
        else $error("frame both accepted and dropped");
    a_query_len: assert property (reqValid |-> reqQuery == (reqParamLen == 5'h00))
        else $error("query flag disagrees with value length");
    a_write_len: assert property (reqValid |-> reqWrite == (reqParamLen != 5'h00))
        else $error("write flag disagrees with value length");
    a_resp_wanted: assert property (reqValid |-> rspWanted == (reqId != 8'h00))
        else $error("response wish disagrees with id");
    a_resp_type: assert property (reqValid |-> rspType == RSP_TYPE)
        else $error("response type not set");
    a_secure_gate: assert property (reqValid && reqSecure |-> secureSession)
        else $error("secure request accepted without session");
    a_apply_frame: assert property (reqValid && reqApply |-> ##[0:1] applyNow)
        else $error("apply bit did not apply");
    a_apply_cmd: assert property (applyPendingChangesCommand |-> ##[1:2] applyNow)
        else $error("apply command ignored");
    a_pend_set: assert property (reqValid && reqWrite && !reqApply |-> ##[0:1] pendingChange)
        else $error("queued write not pending");
    a_pend_clear: assert property (applyNow && !reqValid |-> ##[0:1] !pendingChange)
        else $error("pending change survived apply");
endmodule

// >>> test/rcf_host_model.sv
// host side model that frames and sends remote configuration requests
`timescale 1ns/1ps
module rcf_host_model
    import rcf_pkg::*;
(
    input wire logic  mclk,
    output logic [7:0] rxData,
    output logic       rxValid
);
    initial rxData = 8'h00;
    initial rxValid = 1'b0;
    // ==========================================================
    // byte and frame drivers
    // idle line shows the inverse so a stale byte never looks valid
    task automatic putByte(input logic [7:0] v, input int gap);
        @(posedge mclk);
        rxData <= v;
        rxValid <= 1'b1;
        if (gap > 0)
        begin
            @(posedge mclk);
            rxValid <= 1'b0;
            rxData <= ~v;
            repeat (gap - 1) @(posedge mclk);
        end
    endtask
    task automatic sendReq(input logic [7:0] id, input logic [63:0] a64,
                           input logic [15:0] a16, input logic [7:0] opt,
                           input logic [15:0] cmd, input logic [7:0] val[$],
                           input logic [7:0] sumErr, input int gap);
        logic [7:0] b[$];
        logic [7:0] s;
        b = {REQ_TYPE, id};
        for (int i = 7; i >= 0; i--) b.push_back(a64[i*8+:8]);
        b.push_back(a16[15:8]);
        b.push_back(a16[7:0]);
        b.push_back(opt & ~OPT_RESV_MASK);
        b.push_back(cmd[15:8]);
        b.push_back(cmd[7:0]);
        b = {b, val};
        s = 8'h00;
        foreach (b[i]) s += b[i];
        b = {START_DELIM, 8'h00, 8'(b.size()), b, (CSUM_TARGET - s) ^ sumErr};
        // last byte never waits, so the caller returns on the verdict edge
        foreach (b[i]) putByte(b[i], (i == b.size() - 1) ? 0 : gap);
        @(posedge mclk);
        rxValid <= 1'b0;
        rxData <= ~b[b.size()-1];
    endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the remote configuration request parser
`timescale 1ns/1ps
module tb
    import rcf_pkg::*;
;
    logic mclk = 1'b0, nrst = 1'b0, secureSession = 1'b0, applyCmd = 1'b0;
    logic [7:0] rxData, reqId, rspType;
    logic rxValid, reqValid, rspWanted, reqNoAck, reqApply, reqSecure;
    logic reqQuery, reqWrite, applyNow, pendingChange, frameDropped;
    logic [63:0] reqAddr64;
    logic [15:0] reqAddr16, reqCmd;
    logic [4:0] reqParamLen;
    logic [127:0] reqParam;
    logic [7:0] noVal[$], val[$];
    int failCount = 0, samplesChecked = 0, cycles = 0;
    always #10 mclk = ~mclk;
    rcf_host_model host (.mclk(mclk), .rxData(rxData), .rxValid(rxValid));
    remote_config_request_frame dut (.mclk(mclk), .nrst(nrst), .rxData(rxData),
        .rxValid(rxValid), .secureSession(secureSession),
        .applyPendingChangesCommand(applyCmd), .reqValid(reqValid), .reqId(reqId),
        .rspWanted(rspWanted), .rspType(rspType), .reqAddr64(reqAddr64),
        .reqAddr16(reqAddr16), .reqNoAck(reqNoAck), .reqApply(reqApply),
        .reqSecure(reqSecure), .reqCmd(reqCmd), .reqParamLen(reqParamLen),
        .reqParam(reqParam), .reqQuery(reqQuery), .reqWrite(reqWrite),
        .applyNow(applyNow), .pendingChange(pendingChange), .frameDropped(frameDropped));
    // ==========================================================
    // checking helpers
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // called on the edge that takes the checksum byte; the pulse stands one cycle
    task automatic expectFrame(input logic ok);
        int n;
        n = 0;
        #1;
        while (reqValid !== 1'b1 && frameDropped !== 1'b1 && n < 4)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(reqValid, ok);
        check(frameDropped, !ok);
    endtask
    task automatic printVerdict();
        $display("checks=%0d mismatches=%0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard well above the expected run length
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failCount++;
            printVerdict();
        end
    end
    // ==========================================================
    // scenarios
    initial
    begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        host.putByte(8'h55, 0);
        host.sendReq(8'hfa, 64'h0013a20012345678, 16'hfffe, 8'h00, 16'h5450, noVal, 8'h00, 0);
        expectFrame(1'b1);
        check(reqQuery, 1'b1);
        check(reqId, 8'hfa);
        check(rspWanted, 1'b1);
        check(rspType, RSP_TYPE);
        check(reqCmd, 16'h5450);
        check(reqAddr64, 64'h0013a20012345678);
        check(reqAddr16, 16'hfffe);
        val = '{8'h52, 8'h65, 8'h6d, 8'h6f, 8'h74, 8'h65};
        host.sendReq(8'h27, 64'h0013a20012345678, 16'hfffe, 8'h02, 16'h4e49, val, 8'h00, 1);
        expectFrame(1'b1);
        check(reqWrite, 1'b1);
        check(reqParamLen, 5'h06);
        check(reqParam[127:80], 48'h52656d6f7465);
        check(reqApply, 1'b1);
        check(applyNow, 1'b1);
        val = '{8'h04, 8'h51};
        host.sendReq(8'h00, 64'h0013a20012345678, 16'h1234, 8'h00, 16'h4944, val, 8'h00, 0);
        expectFrame(1'b1);
        check(rspWanted, 1'b0);
        check(pendingChange, 1'b1);
        @(posedge mclk);
        applyCmd <= 1'b1;
        @(posedge mclk);
        applyCmd <= 1'b0;
        #1;
        check(applyNow, 1'b1);
        repeat (2) @(posedge mclk);
        #1;
        check(pendingChange, 1'b0);
        host.sendReq(8'h33, 64'hffffffffffffffff, 16'h1234, 8'h00, 16'h5450, noVal, 8'h01, 0);
        expectFrame(1'b0);
        // zero length frame goes straight to its checksum byte and drops
        host.putByte(START_DELIM, 0);
        host.putByte(8'h00, 0);
        host.putByte(8'h00, 0);
        host.putByte(8'hff, 1);
        expectFrame(1'b0);
        check(reqId, 8'h00);
        val = {};
        for (int i = 0; i < 16; i++) val.push_back(8'(i));
        host.sendReq(8'h41, 64'h0013a20012345678, 16'hfffe, 8'h01, 16'h4e49, val, 8'h00, 0);
        expectFrame(1'b1);
        check(reqParamLen, 5'h10);
        check(reqNoAck, 1'b1);
        check(reqParam[7:0], 8'h0f);
        val.push_back(8'h10);
        host.sendReq(8'h42, 64'h0013a20012345678, 16'hfffe, 8'h00, 16'h4e49, val, 8'h00, 0);
        expectFrame(1'b0);
        host.sendReq(8'h43, 64'h0013a20012345678, 16'hfffe, 8'h10, 16'h5450, noVal, 8'h00, 0);
        expectFrame(1'b0);
        secureSession <= 1'b1;
        host.sendReq(8'h44, 64'h0013a20012345678, 16'hfffe, 8'h10, 16'h5450, noVal, 8'h00, 0);
        expectFrame(1'b1);
        check(reqSecure, 1'b1);
        printVerdict();
    end
endmodule
bind remote_config_request_frame rcf_props u_props (.mclk(mclk), .nrst(nrst),
    .secureSession(secureSession), .applyPendingChangesCommand(applyPendingChangesCommand),
    .reqValid(reqValid), .reqId(reqId), .rspWanted(rspWanted), .rspType(rspType),
    .reqApply(reqApply), .reqSecure(reqSecure), .reqQuery(reqQuery), .reqWrite(reqWrite),
    .reqParamLen(reqParamLen), .applyNow(applyNow), .pendingChange(pendingChange),
    .frameDropped(frameDropped));
